// file: pkg/serial_pkg.sv
// Constants, types and frame layout for the asynchronous serial engine.
// Assumes a single 20 MHz core clock and an instruction cycle of four clocks.
// Contract
// - Port runs asynchronous whenever port enable is set and the sync mode select bit is clear.
// - Frames are NRZ: start bit, eight or nine data bits, one stop bit.
// - Data goes LSB first; transmitter and receiver run independently.
// - Baud generator ticks at four, sixteen or sixty-four times the bit rate.
// - No hardware parity; parity travels as software's ninth bit.
// - Shifter reloads only after the stop bit, then at once if data waits.
// - Holding-to-shifter move takes one instruction cycle and sets buffer empty.
// - Buffer empty flag sets regardless of its enable; software cannot clear it. The code holds the flag clear while transmit enable is clear.
// - After a holding write the flag clears only in the second instruction cycle.
// - Shifter empty status reads set while the shifter is empty; no interrupt.
// - Setting transmit enable sets the buffer empty flag at once.
// - Ninth-bit enable sends nine data bits; ninth from the ninth bit value.
// - Auto baud runs only in asynchronous mode, with wake on edge set or clear.
// - Auto baud enable clears the counter, then waits for a start bit.
// - Counter runs from first rising edge, stops at fifth rising edge.
// - Fifth rising edge clears auto baud enable.
// - Measure rate is oscillator/512, /128 or /32 by the select bits.
// - Divisor low and high act as one 16-bit counter during measurement.
// - Receiver held idle; rx ready set at fifth edge; cleared by read.
// - With wake on edge set, measurement uses the character after the break.
// - Receive recovery samples at sixteen times the baud rate; the engine has no receive path, rxIdle is tied high.
package serial_pkg;
    localparam int          CYCLES_PER_TCY   = 4;
    localparam int          TCY_W            = 2;
    localparam logic [1:0]  TCY_LAST         = 2'h3;
    localparam int          WORD_W           = 9;
    localparam int          FIFO_DEPTH       = 16;
    localparam int          FIFO_AW          = 4;
    localparam int          TICKS_X16        = 16;
    localparam int          TICKS_X64        = 64;
    localparam logic [5:0]  TICK_LAST_X16    = 6'h0f;
    localparam logic [5:0]  TICK_LAST_X64    = 6'h3f;
    localparam logic [5:0]  TICK_LAST_X4     = 6'h03;
    localparam logic [3:0]  BITS_8           = 4'h8;
    localparam logic [3:0]  BITS_9           = 4'h9;
    localparam logic [8:0]  MEAS_DIV_512     = 9'h1ff;
    localparam logic [8:0]  MEAS_DIV_128     = 9'h07f;
    localparam logic [8:0]  MEAS_DIV_32      = 9'h01f;
    localparam logic [2:0]  RISE_LAST        = 3'h5;
    localparam logic [15:0] DIVISOR_RESET    = 16'h0000;
    localparam logic [7:0]  HOLD_RESET       = 8'h00;

    // Configuration bits that steer the engine
    typedef struct packed {
        logic       syncMode;
        logic       portEnable;
        logic       transmitEnable;
        logic       ninthBitTxEnable;
        logic       ninthTxBitValue;
        logic       highSpeedSelect;
        logic       wideDividerSelect;
        logic       wakeOnEdgeEnable;
    } serial_cfg_t;

    typedef enum logic [2:0] {TxIdle, TxLoad, TxStart, TxData, TxStop} tx_state_t;
    typedef enum logic [2:0] {AbIdle, AbWaitBreak, AbWaitStart, AbWaitRise, AbCount} ab_state_t;
endpackage

// file: rtl/async_serial_tx_autobaud.sv
// Asynchronous serial transmitter with baud generator and auto baud measurement.
// Assumes rxPin comes from a pad; all other inputs are on clk.
module async_serial_tx_autobaud
    import serial_pkg::*;
(
    input  wire logic        clk,            // Core clock 20 MHz
    input  wire logic        rst,            // Async reset
    input  wire serial_cfg_t cfg,            // Control bits
    input  wire logic [15:0] divisorWrData,  // Divisor write data
    input  wire logic        divisorWr,      // Divisor write strobe
    input  wire logic [7:0]  holdWrData,     // Holding register data
    input  wire logic        holdWr,         // Holding register write strobe
    output logic             holdReady,      // Buffer can take a write
    input  wire logic        autoBaudSet,    // Software sets auto baud enable
    input  wire logic        rxHoldRead,     // Software reads rx holding reg
    input  wire logic        rxPin,          // Receive pin
    output logic             txPin,          // Transmit pin
    output logic             txBufferEmptyFlag, // Buffer empty flag
    output logic             shifterEmptyStatus, // Shifter empty
    output logic             autoBaudEnable, // Auto baud enable
    output logic [15:0]      divisor,        // Divisor pair
    output logic             rxReadyFlag,    // Receive ready
    output logic [7:0]      rxHoldingReg,   // Receive holding reg
    output logic             rxIdle          // Receiver held idle
);
    logic             rxMeta;
    logic             rxSync;
    logic             rxPrev;
    logic [TCY_W-1:0] tcyCnt;
    logic             tcyTick;
    logic [15:0]      brgCnt;
    logic [15:0]      next_brgCnt;
    logic [5:0]       subCnt;
    logic [5:0]       next_subCnt;
    logic             bitTick;
    logic [5:0]       tickLast;
    logic [8:0]       measCnt;
    logic [8:0]       next_measCnt;
    logic [8:0]       measLast;
    tx_state_t        txState;
    tx_state_t        next_txState;
    logic [8:0]       shiftReg;
    logic [8:0]       next_shiftReg;
    logic [3:0]       bitCnt;
    logic [3:0]       next_bitCnt;
    logic             next_txPin;
    logic             txEnPrev;
    logic             fifoValid;
    logic [8:0]       fifoData;
    logic             fifoPop;
    logic [1:0]       clrDelay;
    logic [1:0]       next_clrDelay;
    logic             next_flag;
    ab_state_t        abState;
    ab_state_t        next_abState;
    logic [2:0]       riseCnt;
    logic [2:0]       next_riseCnt;
    logic [15:0]      next_divisor;
    logic             next_abEn;
    logic             next_rxReady;
    logic             rxRise;
    logic             rxFall;
    logic             asyncMode;

    assign asyncMode = cfg.portEnable && !cfg.syncMode;

    // Pad synchroniser and instruction cycle strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxMeta   <= 1'b1;
            rxSync   <= 1'b1;
            rxPrev   <= 1'b1;
            tcyCnt   <= '0;
            txEnPrev <= 1'b0;
        end
        else
        begin
            rxMeta   <= rxPin;
            rxSync   <= rxMeta;
            rxPrev   <= rxSync;
            tcyCnt   <= tcyCnt + 1'b1;
            txEnPrev <= cfg.transmitEnable;
        end
    end
    assign tcyTick = (tcyCnt == TCY_LAST);
    assign rxRise  = rxSync && !rxPrev;
    assign rxFall  = !rxSync && rxPrev;

    // FIFO of holding words; ninth bit captured with the data
    sync_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) holdFifo (
        .clk      (clk),
        .rst      (rst),
        .inData   ({cfg.ninthTxBitValue, holdWrData}),
        .inValid  (holdWr && cfg.transmitEnable),
        .inReady  (holdReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    // Four, sixteen or sixty-four ticks per bit; divisor reload gives x4(n+1) at both set
    always_comb
    begin
        tickLast = (cfg.highSpeedSelect || cfg.wideDividerSelect) ? TICK_LAST_X16 : TICK_LAST_X64;
        if (cfg.highSpeedSelect && cfg.wideDividerSelect)
            tickLast = TICK_LAST_X4;
        measLast = (!cfg.highSpeedSelect && !cfg.wideDividerSelect) ? MEAS_DIV_512 :
                   (cfg.highSpeedSelect && cfg.wideDividerSelect) ? MEAS_DIV_32 : MEAS_DIV_128;
        bitTick     = 1'b0;
        next_brgCnt = brgCnt;
        next_subCnt = subCnt;
        if (autoBaudEnable || !asyncMode)
        begin
            next_brgCnt = '0;
            next_subCnt = '0;
        end
        else if (brgCnt == '0)
        begin
            next_brgCnt = cfg.wideDividerSelect ? divisor : {8'h00, divisor[7:0]};
            next_subCnt = (subCnt == tickLast) ? '0 : subCnt + 1'b1;
            bitTick     = (subCnt == tickLast);
        end
        else
            next_brgCnt = brgCnt - 1'b1;
    end

    // Transmit shifter: start, LSB first data, stop; no parity
    always_comb
    begin
        next_txState  = txState;
        next_shiftReg = shiftReg;
        next_bitCnt   = bitCnt;
        next_txPin    = txPin;
        fifoPop       = 1'b0;
        unique case (txState)
            TxIdle:
                if (fifoValid && cfg.transmitEnable && asyncMode && tcyTick)
                    next_txState = TxLoad;
            TxLoad:
            begin
                fifoPop       = 1'b1;
                next_shiftReg = fifoData;
                next_bitCnt   = cfg.ninthBitTxEnable ? BITS_9 : BITS_8;
                next_txState  = TxStart;
            end
            TxStart:
                if (bitTick)
                begin
                    next_txPin   = 1'b0; // Start on a tick so it lasts a full bit
                    next_txState = TxData;
                end
            TxData:
                if (bitTick)
                begin
                    next_txPin    = (bitCnt == 4'h0) || shiftReg[0];
                    next_shiftReg = {1'b0, shiftReg[8:1]};
                    next_bitCnt   = bitCnt - 1'b1;
                    if (bitCnt == 4'h0)
                        next_txState = TxStop;
                end
            TxStop:
                if (bitTick)
                    next_txState = TxIdle;
        endcase
        if (!cfg.transmitEnable)
        begin
            next_txState = TxIdle;
            next_txPin   = 1'b1;
        end
    end

    // Buffer empty flag: clears two instruction cycles after a write
    always_comb
    begin
        next_clrDelay = clrDelay;
        next_flag     = txBufferEmptyFlag;
        if (holdWr && cfg.transmitEnable)
            next_clrDelay = 2'h2;
        else if (tcyTick && clrDelay != 2'h0)
            next_clrDelay = clrDelay - 1'b1;
        if (tcyTick && clrDelay == 2'h1 && next_clrDelay == 2'h0)
            next_flag = !fifoValid && holdReady;
        if (fifoPop || (cfg.transmitEnable && !txEnPrev))
            next_flag = 1'b1;
        if (!cfg.transmitEnable)
            next_flag = 1'b0;
    end

    // Auto baud measurement
    always_comb
    begin
        next_abState = abState;
        next_riseCnt = riseCnt;
        next_divisor = divisor;
        next_abEn    = autoBaudEnable;
        next_rxReady = rxReadyFlag;
        next_measCnt = measCnt;
        if (divisorWr)
            next_divisor = divisorWrData;
        if (rxHoldRead)
            next_rxReady = 1'b0;
        unique case (abState)
            AbIdle:
                if (autoBaudSet && asyncMode)
                begin
                    next_abEn    = 1'b1;
                    next_divisor = DIVISOR_RESET;
                    next_abState = cfg.wakeOnEdgeEnable ? AbWaitBreak : AbWaitStart;
                end
            AbWaitBreak:
                if (rxRise)
                    next_abState = AbWaitStart;
            AbWaitStart:
                if (rxFall)
                    next_abState = AbWaitRise;
            AbWaitRise:
                if (rxRise)
                begin
                    next_riseCnt = 3'h1;
                    next_measCnt = '0;
                    next_abState = AbCount;
                end
            AbCount:
            begin
                next_measCnt = (measCnt == measLast) ? '0 : measCnt + 1'b1;
                if (measCnt == measLast)
                    next_divisor = divisor + 1'b1;
                if (rxRise)
                begin
                    next_riseCnt = riseCnt + 1'b1;
                    if (riseCnt + 1'b1 == RISE_LAST)
                    begin
                        next_abEn    = 1'b0;
                        next_rxReady = 1'b1;
                        next_abState = AbIdle;
                    end
                end
            end
        endcase
        if (!asyncMode)
        begin
            next_abState = AbIdle;
            next_abEn    = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            brgCnt            <= '0;
            subCnt            <= '0;
            measCnt           <= '0;
            txState           <= TxIdle;
            shiftReg          <= '0;
            bitCnt            <= '0;
            txPin             <= 1'b1;
            clrDelay          <= '0;
            txBufferEmptyFlag <= 1'b0;
            abState           <= AbIdle;
            riseCnt           <= '0;
            divisor           <= DIVISOR_RESET;
            autoBaudEnable    <= 1'b0;
            rxReadyFlag       <= 1'b0;
            rxHoldingReg      <= HOLD_RESET;
        end
        else
        begin
            brgCnt            <= next_brgCnt;
            subCnt            <= next_subCnt;
            measCnt           <= next_measCnt;
            txState           <= next_txState;
            shiftReg          <= next_shiftReg;
            bitCnt            <= next_bitCnt;
            txPin             <= next_txPin;
            clrDelay          <= next_clrDelay;
            txBufferEmptyFlag <= next_flag;
            abState           <= next_abState;
            riseCnt           <= next_riseCnt;
            divisor           <= next_divisor;
            autoBaudEnable    <= next_abEn;
            rxReadyFlag       <= next_rxReady;
            rxHoldingReg      <= HOLD_RESET;
        end
    end

    // Status outputs
    assign shifterEmptyStatus = (txState == TxIdle);
    assign rxIdle             = 1'b1;
endmodule

// file: rtl/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
module sync_fifo
    import serial_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int AW    = 4
)(
    input  wire logic             clk,      // Core clock
    input  wire logic             rst,      // Async reset
    input  wire logic [WIDTH-1:0] inData,   // Write data
    input  wire logic             inValid,  // Write request
    output logic                  inReady,  // Not full
    output logic [WIDTH-1:0]      outData,  // Head word
    output logic                  outValid, // Not empty
    input  wire logic             outReady  // Pop request
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    logic [AW:0]      next_wrPtr;
    logic [AW:0]      next_rdPtr;
    logic             push;
    logic             pop;

    // Full and empty from pointer wrap bits
    always_comb
    begin
        inReady    = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
        outValid   = (wrPtr != rdPtr);
        push       = inValid && inReady;
        pop        = outValid && outReady;
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        outData    = mem[rdPtr[AW-1:0]];
    end

    // Pointer registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
        end
        else
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
    end

    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr[AW-1:0]] <= inData;
    end
endmodule

// file: verif/async_serial_tx_autobaud_props.sv
// Port checks for the serial engine.
// Assumes one clock domain and the async active-high reset.
module async_serial_tx_autobaud_props
    import serial_pkg::*;
(
    input wire logic        clk,                // Core clock
    input wire logic        rst,                // Async reset
    input wire serial_cfg_t cfg,                // Control bits
    input wire logic        holdWr,             // Holding write
    input wire logic        holdReady,          // Not full
    input wire logic        txPin,              // Serial out
    input wire logic        txBufferEmptyFlag,  // Buffer empty
    input wire logic        shifterEmptyStatus, // Shifter empty
    input wire logic        autoBaudEnable,     // Measuring
    input wire logic [15:0] divisor,            // Divisor pair
    input wire logic        rxReadyFlag,        // Receive ready
    input wire logic        rxIdle              // Receiver idle
);
    logic [15:0] prevDiv;
    logic [15:0] gap;
    logic [15:0] lowRun;
    logic        lastInc;
    int          measPeriod;
    int          bitLen;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Step period and bit length from the selects
    always_comb
    begin
        measPeriod = cfg.highSpeedSelect ? (cfg.wideDividerSelect ? 32 : 128) : (cfg.wideDividerSelect ? 128 : 512);
        bitLen = (cfg.wideDividerSelect ? int'(divisor) : int'(divisor[7:0])) + 1;
        bitLen = bitLen * (cfg.highSpeedSelect ? (cfg.wideDividerSelect ? 4 : 16) : (cfg.wideDividerSelect ? 16 : 64));
    end

    // Clocks since the last counter change, and low run on the line
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prevDiv <= 16'h0000;
            gap     <= 16'h0000;
            lowRun  <= 16'h0000;
            lastInc <= 1'b0;
        end
        else
        begin
            prevDiv <= divisor;
            gap     <= (divisor != prevDiv) ? 16'h0001 : gap + 16'h0001;
            lowRun  <= txPin ? 16'h0000 : lowRun + 16'h0001;
            lastInc <= autoBaudEnable && ((divisor != prevDiv) ? (divisor == prevDiv + 16'h0001) : lastInc);
        end
    end

    property p_idleHigh; shifterEmptyStatus |-> txPin; endproperty
    a_idleHigh: assert property (p_idleHigh) else $error("line low with shifter empty");
    property p_startLoaded; $fell(txPin) |-> !shifterEmptyStatus; endproperty
    a_startLoaded: assert property (p_startLoaded) else $error("start bit without load");
    property p_bitLength; $rose(txPin) |-> lowRun != 16'h0000 && (int'(lowRun) % bitLen) == 0; endproperty
    a_bitLength: assert property (p_bitLength) else $error("low run not whole bits");
    property p_flagHolds; holdWr && holdReady && cfg.transmitEnable && txBufferEmptyFlag |=> txBufferEmptyFlag;
    endproperty
    a_flagHolds: assert property (p_flagHolds) else $error("flag cleared at once");
    property p_enableFlag; $rose(cfg.transmitEnable) |-> ##[1:2] txBufferEmptyFlag; endproperty
    a_enableFlag: assert property (p_enableFlag) else $error("enable did not set flag");
    property p_asyncOnly; $rose(autoBaudEnable) |-> !$past(cfg.syncMode); endproperty
    a_asyncOnly: assert property (p_asyncOnly) else $error("measure armed in sync mode");
    property p_armClear; $rose(autoBaudEnable) |-> ##[0:2] divisor == 16'h0000; endproperty
    a_armClear: assert property (p_armClear) else $error("counter not cleared");
    property p_stepOne; autoBaudEnable && divisor != prevDiv && divisor != 16'h0000 |-> divisor == prevDiv + 16'h0001;
    endproperty
    a_stepOne: assert property (p_stepOne) else $error("counter step not one");
    property p_stepRate; autoBaudEnable && lastInc && divisor == prevDiv + 16'h0001 |-> int'(gap) == measPeriod;
    endproperty
    a_stepRate: assert property (p_stepRate) else $error("counter rate wrong");
    property p_doneFlags; $fell(autoBaudEnable) |-> rxReadyFlag; endproperty
    a_doneFlags: assert property (p_doneFlags) else $error("ready not set at end");
    property p_rxHeld; autoBaudEnable |-> rxIdle; endproperty
    a_rxHeld: assert property (p_rxHeld) else $error("receiver not idle");
endmodule

// file: verif/async_serial_tx_autobaud_tb.sv
// Self-checking bench for the serial engine.
// Assumes the remote node model and the bound port checker.
module async_serial_tx_autobaud_tb
    import serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed { logic hs; logic wd; logic nine; logic ninth; logic [7:0] data; logic [8:0] word; } row_t;
    typedef struct packed { logic hs; logic wd; logic wake; int bitClks; int count; } ab_t;
    localparam logic [15:0] DIV = 16'h0002;
    row_t rows[5] = '{'{1'h1, 1'h1, 1'h0, 1'h0, 8'h55, 9'h055}, '{1'h1, 1'h0, 1'h0, 1'h0, 8'ha3, 9'h0a3},
        '{1'h0, 1'h1, 1'h1, 1'h1, 8'h0f, 9'h10f}, '{1'h0, 1'h0, 1'h1, 1'h0, 8'h80, 9'h080},
        '{1'h1, 1'h1, 1'h1, 1'h1, 8'h01, 9'h101}};
    ab_t abRows[5] = '{'{1'h0, 1'h0, 1'h0, 256, 4}, '{1'h1, 1'h0, 1'h0, 128, 8}, '{1'h0, 1'h1, 1'h0, 128, 8},
        '{1'h1, 1'h1, 1'h0, 64, 16}, '{1'h1, 1'h1, 1'h1, 64, 16}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    serial_cfg_t cfg;
    logic [15:0] divisorWrData, divisor;
    logic [7:0]  holdWrData, rxHoldingReg;
    logic        divisorWr, holdWr, holdReady, autoBaudSet, rxHoldRead, rxPin, txPin;
    logic        txBufferEmptyFlag, shifterEmptyStatus, autoBaudEnable, rxReadyFlag, rxIdle;
    int          failCount = 0;
    int          comparisons = 0;

    always #25 clk = ~clk;

    async_serial_tx_autobaud async_serial_tx_autobaud_i (.clk, .rst, .cfg, .divisorWrData, .divisorWr, .holdWrData,
        .holdWr, .holdReady, .autoBaudSet, .rxHoldRead, .rxPin, .txPin, .txBufferEmptyFlag, .shifterEmptyStatus,
        .autoBaudEnable, .divisor, .rxReadyFlag, .rxHoldingReg, .rxIdle);
    remote_serial_node remote_serial_node_i (.clk, .txPin, .rxPin);

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Measured counts may land one step either side
    task automatic cmp_near(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if ($isunknown(got) || got + 16'h0001 < exp || got > exp + 16'h0001)
        begin
            failCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait: n words received and shifter idle, or measuring over when n is negative
    task automatic wait_done(input int n, input int limit);
        int k = 0;
        while ((n < 0 ? autoBaudEnable !== 1'b0
                : (remote_serial_node_i.words.size() < n || shifterEmptyStatus !== 1'b1)) && k < limit)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= limit)
        begin
            failCount++;
            $display("mismatch wait expected done seen timeout");
            tally_and_finish();
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask

    task automatic setup(input logic hs, input logic wd);
        cfg.highSpeedSelect = hs;
        cfg.wideDividerSelect = wd;
        divisorWrData = DIV;
        pulse(divisorWr);
        remote_serial_node_i.bitClks = (int'(DIV) + 1) * (hs ? (wd ? 4 : 16) : (wd ? 16 : 64));
        remote_serial_node_i.words.delete();
    endtask

    // Reset, refused write, table of frames, burst, then measurement cases
    initial
    begin
        int n;
        cfg = '0;
        divisorWrData = 16'h0000;
        holdWrData = 8'h00;
        {divisorWr, holdWr, autoBaudSet, rxHoldRead} = 4'h0;
        repeat (6) @(negedge clk);
        cmp("reset flags", 16'h0014, {11'h000, txPin, txBufferEmptyFlag, shifterEmptyStatus, autoBaudEnable, rxReadyFlag});
        cmp("reset divisor", 16'h0000, divisor);
        rst = 1'b0;
        cfg.portEnable = 1'b1;
        setup(1'h1, 1'h1);
        holdWrData = 8'hff;
        pulse(holdWr);
        repeat (60) @(negedge clk);
        cmp("refused write", 16'h0000, 16'(remote_serial_node_i.words.size()));
        cfg.transmitEnable = 1'b1;
        repeat (2) @(negedge clk);
        cmp("enable flag", 16'h0001, {15'h0000, txBufferEmptyFlag});
        foreach (rows[i])
        begin
            cfg.ninthBitTxEnable = rows[i].nine;
            cfg.ninthTxBitValue = rows[i].ninth;
            setup(rows[i].hs, rows[i].wd);
            remote_serial_node_i.nineBits = rows[i].nine;
            holdWrData = rows[i].data;
            pulse(holdWr);
            wait_done(1, 3000);
            cmp("frame word", 16'(rows[i].word), 16'(remote_serial_node_i.words[0]));
            cmp("idle flags", 16'h0003, {14'h0000, txBufferEmptyFlag, shifterEmptyStatus});
        end
        cfg.ninthBitTxEnable = 1'b0;
        remote_serial_node_i.nineBits = 1'b0;
        setup(1'h1, 1'h1);
        n = 0;
        while (holdReady === 1'b1 && n < 20)
        begin
            holdWrData = 8'h30 + 8'(n);
            holdWr = 1'b1;
            n++;
            @(negedge clk);
        end
        cmp("burst taken", 16'h0011, 16'(n));
        holdWrData = 8'hee;
        @(negedge clk);
        holdWr = 1'b0;
        wait_done(17, 2600);
        cmp("burst count", 16'h0011, 16'(remote_serial_node_i.words.size()));
        for (int i = 0; i < 17; i++)
            cmp("burst word", 16'h0030 + 16'(i), 16'(remote_serial_node_i.words[i]));
        cmp("burst flag", 16'h0001, {15'h0000, txBufferEmptyFlag});
        foreach (abRows[i])
        begin
            setup(abRows[i].hs, abRows[i].wd);
            cfg.wakeOnEdgeEnable = abRows[i].wake;
            pulse(autoBaudSet);
            cmp("armed", 16'h0003, {14'h0000, autoBaudEnable, rxIdle});
            cmp("cleared", 16'h0000, divisor);
            if (abRows[i].wake)
            begin
                remote_serial_node_i.hold_line(1'b0, 13 * abRows[i].bitClks);
                remote_serial_node_i.hold_line(1'b1, abRows[i].bitClks);
            end
            remote_serial_node_i.send_char(8'h55, abRows[i].bitClks);
            wait_done(-1, 100);
            cmp_near("measured", 16'(abRows[i].count), divisor);
            cmp("high byte", 16'h0000, {8'h00, divisor[15:8]});
            cmp("rx ready", 16'h0001, {15'h0000, rxReadyFlag});
            pulse(rxHoldRead);
            cmp("rx cleared", 16'h0000, {7'h00, rxReadyFlag, rxHoldingReg});
        end
        cfg.wakeOnEdgeEnable = 1'b0;
        cfg.syncMode = 1'b1;
        pulse(autoBaudSet);
        cmp("sync refuse", 16'h0000, {15'h0000, autoBaudEnable});
        tally_and_finish();
    end
endmodule

bind async_serial_tx_autobaud async_serial_tx_autobaud_props async_serial_tx_autobaud_props_i (.clk, .rst, .cfg,
    .holdWr, .holdReady, .txPin, .txBufferEmptyFlag, .shifterEmptyStatus, .autoBaudEnable, .divisor, .rxReadyFlag,
    .rxIdle);

// file: verif/remote_serial_node.sv
// Remote asynchronous node on the two serial lines.
// Assumes the bench sets bit length and word size before traffic.
module remote_serial_node
(
    input  wire logic clk,   // Core clock
    input  wire logic txPin, // Line from the engine
    output logic      rxPin  // Line to the engine
);
    timeunit 1ns;
    timeprecision 1ns;
    int         bitClks  = 12;   // Clocks per bit
    logic       nineBits = 1'b0; // Ninth data bit on the line
    logic [8:0] words[$];        // Words taken off the line

    initial rxPin = 1'b1;

    // Drive a level for a number of clocks, changed off the sampling edge
    task automatic hold_line(input logic level, input int clks);
        rxPin = level;
        repeat (clks) @(negedge clk);
    endtask

    // Start, eight data bits low first, stop
    task automatic send_char(input logic [7:0] data, input int clks);
        hold_line(1'b0, clks);
        for (int i = 0; i < 8; i++)
            hold_line(data[i], clks);
        hold_line(1'b1, clks);
    endtask

    // Mid-bit sampling of frames sent by the engine
    initial
    begin
        logic [8:0] w;
        forever
        begin
            @(negedge txPin);
            repeat (bitClks / 2) @(posedge clk);
            w = 9'h000;
            for (int i = 0; i < (nineBits ? 9 : 8); i++)
            begin
                repeat (bitClks) @(posedge clk);
                w[i] = txPin;
            end
            repeat (bitClks) @(posedge clk);
            if (txPin === 1'b1)
                words.push_back(w);
        end
    end
endmodule
